// >>> hw/frd_consts.svh
// Offsets, field positions, reset values and rate codes of the rate,
// diagnostic and status block.
// Assumes inclusion by its bare name.
`ifndef FRD_CONSTS_SVH
`define FRD_CONSTS_SVH

// Register byte offsets on the AXI4-Lite slave
`define FRD_OFF_DIN 8'h00
`define FRD_OFF_CFG 8'h04
`define FRD_OFF_RSEL 8'h08
`define FRD_OFF_DOUT 8'h0c
`define FRD_OFF_MODE 8'h10
`define FRD_OFF_MAIN 8'h14
`define FRD_OFF_DATA 8'h18

// Field positions
`define FRD_BIT_DISKCHG 7
`define FRD_BIT_DMAGATE 3
`define FRD_BIT_SKIPPRE 2
`define FRD_BIT_SWRST 2

// Rate codes, double density
`define FRD_RATE_1M 2'b11
`define FRD_RATE_500K 2'b00
`define FRD_RATE_300K 2'b01
`define FRD_RATE_250K 2'b10

// Reset values
`define FRD_RST_RATE `FRD_RATE_250K
`define FRD_RST_STATUS 8'h00
`define FRD_RST_DOUT 8'h00

// Termination codes
`define FRD_TC_NORMAL 2'b00
`define FRD_TC_ABNORMAL 2'b01
`define FRD_TC_INVALID 2'b10
`define FRD_TC_READYCHG 2'b11

// AXI responses
`define FRD_RESP_OKAY 2'b00
`define FRD_RESP_SLVERR 2'b10

`endif

// >>> hw/frd_pkg.sv
// Types shared by the register block and its bench.
// Assumes frd_consts.svh is on the include path.
`include "frd_consts.svh"

package frd_pkg;

    // Register view selected by software
    typedef enum logic [1:0] {
        FRD_MODE_BASIC = 2'b00,
        FRD_MODE_ENHANCED = 2'b01,
        FRD_MODE_COMPACT = 2'b10
    } frd_mode_t;

    // Command phase seen by the result path
    typedef enum logic [1:0] {
        FRD_PH_IDLE = 2'b00,
        FRD_PH_RESULT0 = 2'b01,
        FRD_PH_RESULT1 = 2'b10
    } frd_phase_t;

    // Sequencer report when an execution phase ends
    typedef struct packed {
        logic [1:0] term_code;
        logic seek_done;
        logic equip_fault;
        logic head_sel;
        logic [1:0] drive_num;
        logic [7:0] status_one;
        logic has_result;
    } frd_exec_end_t;

    // Drive-side inputs
    typedef struct packed {
        logic disk_changed_in;
        logic head_select_out;
    } frd_drive_t;

endpackage

// >>> hw/frd_rate_diag_regs.sv
// Rate configuration, digital input views and result status bytes of a
// floppy controller, reached over AXI4-Lite.
// Assumes a sequencer reports execution end and polling.
//
// Summary of operation
// (RULE_01) Enhanced view returns ones on input register bits 6 to 3.
// (RULE_02) Bits 1..0 of input view show latest programmed rate code; the enhanced view puts it on bits 2..1; the basic view reads zeros there.
// (RULE_03) Enhanced bit 0 low for two fast rates, high for slow rates.
// (RULE_04) Compact bit 7 shows disk-changed input active low.
// (RULE_05) Compact view returns zeros on bits 6 to 4.
// (RULE_06) Compact bit 3 mirrors the DMA gate enable bit.
// (RULE_07) Compact bit 2 mirrors the stored skip-precomp bit.
// (RULE_08) Config write only; soft reset keeps it; hard reset loads 250k.
// (RULE_09) Operating rate follows latest config or rate-select write.
// (RULE_10) Config bits 1..0 choose the data rate.
// (RULE_11) Host writes zeros to config bits 7..2 outside compact mode.
// (RULE_12) Compact config bit 2 stored, read back only, soft reset keeps.
// (RULE_13) Result bytes come from data register only in result phase.
// (RULE_14) Main status register is always readable and valid.
// (RULE_15) Status zero bits 7..6 give the termination code.
// (RULE_16) Ready-change code only during polling after a reset.
// (RULE_17) Status zero bit 5 set on seek or recalibrate completion.
// (RULE_18) Status zero bit 4 set when track zero fails on recalibrate.
// (RULE_19) Status zero bit 3 always reads zero.
// (RULE_20) Rate codes 11=1M, 00=500k, 01=300k, 10=250k; FM halves.
// (RULE_21) Head and drive bits captured when execution phase ends.
`timescale 1ns/1ps
`default_nettype none

module frd_rate_diag_regs
    import frd_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    // Clock, reset, enable
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic clk_en,
    // AXI4-Lite write channels
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read channels
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Drive side
    input wire frd_pkg::frd_drive_t drive_in,
    // Sequencer side
    input wire logic exec_end,
    input wire frd_pkg::frd_exec_end_t exec_info,
    input wire logic polling_active,
    input wire logic drive_busy,
    // Controller state outputs
    output logic [1:0] data_rate,
    output logic single_density,
    output logic dense_rate_flag,
    output logic dma_gate_enable,
    output logic soft_reset,
    output logic result_phase
);
    import frd_pkg::*;

    // Word decode reads address bits 7..2
    // Refused at elaboration when the bus is narrower
    if (ADDR_W < 8) begin : g_addr_check
        $error("ADDR_W too small for the register map");
    end

    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    logic [1:0] rate_q;
    logic skip_precomp_q;
    logic [7:0] dout_q;
    frd_mode_t mode_q;
    logic fm_q;
    logic after_reset_q;
    logic [7:0] status_zero_q;
    logic [7:0] status_one_q;
    frd_phase_t phase_q;

    // AXI handshake state
    logic aw_held_q;
    logic w_held_q;
    logic [ADDR_W-1:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0] rresp_q;

    // Word decode, both directions
    function automatic logic [7:0] frd_word(input logic [ADDR_W-1:0] a);
        frd_word = {a[7:2], 2'b00};
    endfunction

    // Slow rates clear the density flag
    function automatic logic frd_is_slow(input logic [1:0] r);
        frd_is_slow = (r == `FRD_RATE_300K) || (r == `FRD_RATE_250K); // RULE_03
    endfunction

    // ------------------------------------------------------------
    // Write path
    // ------------------------------------------------------------
    logic do_write;
    logic [7:0] wr_off;
    logic wr_hit;
    logic [7:0] wbyte;

    assign s_axi_awready = !aw_held_q && !bvalid_q;
    assign s_axi_wready = !w_held_q && !bvalid_q;
    assign do_write = aw_held_q && w_held_q && !bvalid_q && clk_en;
    assign wr_off = frd_word(awaddr_q);
    assign wbyte = wstrb_q[0] ? wdata_q[7:0] : 8'h00;

    // Writable offsets
    always_comb begin
        case (wr_off)
            `FRD_OFF_CFG, `FRD_OFF_RSEL, `FRD_OFF_DOUT, `FRD_OFF_MODE: wr_hit = 1'b1;
            default: wr_hit = 1'b0;
        endcase
    end

    // Capture address and data, either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            awaddr_q <= '0;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
        end else if (clk_en) begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_q <= 1'b1;
                awaddr_q <= s_axi_awaddr;
            end else if (do_write) begin
                aw_held_q <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_q <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end else if (do_write) begin
                w_held_q <= 1'b0;
            end
        end
    end

    // Write response
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_q <= 1'b0;
            bresp_q <= `FRD_RESP_OKAY;
        end else if (clk_en) begin
            if (do_write) begin
                bvalid_q <= 1'b1;
                bresp_q <= wr_hit ? `FRD_RESP_OKAY : `FRD_RESP_SLVERR;
            end else if (s_axi_bready) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;

    // Soft reset pulse on a run-bit fall
    logic soft_rst_pulse;
    assign soft_rst_pulse = do_write && wstrb_q[0] && (wr_off == `FRD_OFF_DOUT)
        && !wdata_q[`FRD_BIT_SWRST] && dout_q[`FRD_BIT_SWRST];

    // ------------------------------------------------------------
    // Rate and configuration
    // ------------------------------------------------------------
    // Last write to either rate register wins
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rate_q <= `FRD_RST_RATE; // RULE_08
            fm_q <= 1'b0;
        end else if (do_write && wstrb_q[0]) begin
            if (wr_off == `FRD_OFF_CFG) begin
                rate_q <= wbyte[1:0]; // RULE_09 RULE_10
            end else if (wr_off == `FRD_OFF_RSEL) begin
                rate_q <= wbyte[1:0]; // RULE_09
                fm_q <= wbyte[5];
            end
        end
    end

    // Skip-precomp bit, stored only in compact mode
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            skip_precomp_q <= 1'b0;
        end else if (do_write && wstrb_q[0] && wr_off == `FRD_OFF_CFG
                     && mode_q == FRD_MODE_COMPACT) begin
            skip_precomp_q <= wbyte[`FRD_BIT_SKIPPRE]; // RULE_12
        end
    end

    // Digital output register and mode select
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            dout_q <= `FRD_RST_DOUT;
            mode_q <= FRD_MODE_BASIC;
        end else if (do_write && wstrb_q[0]) begin
            if (wr_off == `FRD_OFF_DOUT) begin
                dout_q <= wbyte;
            end else if (wr_off == `FRD_OFF_MODE) begin
                case (wbyte[1:0])
                    2'b01: mode_q <= FRD_MODE_ENHANCED;
                    2'b10: mode_q <= FRD_MODE_COMPACT;
                    default: mode_q <= FRD_MODE_BASIC;
                endcase
            end
        end
    end

    // Rate outputs; 1M illegal in FM
    assign data_rate = rate_q; // RULE_20
    assign single_density = fm_q && (rate_q != `FRD_RATE_1M); // RULE_20
    assign dense_rate_flag = !frd_is_slow(rate_q);
    assign dma_gate_enable = dout_q[`FRD_BIT_DMAGATE];
    assign soft_reset = !dout_q[`FRD_BIT_SWRST];

    // ------------------------------------------------------------
    // Result status bytes
    // ------------------------------------------------------------
    // Polling window after a hard or soft reset
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            after_reset_q <= 1'b1;
        end else if (clk_en) begin
            if (soft_rst_pulse) begin
                after_reset_q <= 1'b1;
            end else if (exec_end && !polling_active) begin
                after_reset_q <= 1'b0;
            end
        end
    end

    logic [1:0] tc_d;
    always_comb begin
        tc_d = exec_info.term_code; // RULE_15
        if (tc_d == `FRD_TC_READYCHG && !(polling_active && after_reset_q)) begin
            tc_d = `FRD_TC_ABNORMAL; // RULE_16
        end
    end

    logic rd_data_pop;

    // Capture at execution end, offer bytes after
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            status_zero_q <= `FRD_RST_STATUS;
            status_one_q <= `FRD_RST_STATUS;
            phase_q <= FRD_PH_IDLE;
        end else if (clk_en) begin
            if (exec_end) begin
                status_zero_q <= {tc_d, // RULE_15
                                  exec_info.seek_done, // RULE_17
                                  exec_info.equip_fault, // RULE_18
                                  1'b0, // RULE_19
                                  drive_in.head_select_out, // RULE_21
                                  exec_info.drive_num}; // RULE_21
                status_one_q <= exec_info.status_one;
                phase_q <= exec_info.has_result ? FRD_PH_RESULT0 : FRD_PH_IDLE;
            end else if (rd_data_pop) begin
                case (phase_q)
                    FRD_PH_RESULT0: phase_q <= FRD_PH_RESULT1;
                    FRD_PH_RESULT1: phase_q <= FRD_PH_IDLE;
                    default: phase_q <= FRD_PH_IDLE;
                endcase
            end
        end
    end

    assign result_phase = (phase_q != FRD_PH_IDLE);

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    logic [7:0] rd_off;
    logic do_read;
    logic [7:0] rd_byte;
    logic rd_hit;
    logic [7:0] main_status;

    assign s_axi_arready = !rvalid_q;
    assign do_read = s_axi_arvalid && s_axi_arready && clk_en;
    assign rd_off = frd_word(s_axi_araddr);
    assign rd_data_pop = do_read && (rd_off == `FRD_OFF_DATA) && result_phase; // RULE_13

    // Always valid main status
    assign main_status = {!drive_busy, result_phase, 2'b00,
                          drive_busy, 3'b000}; // RULE_14

    // Readable words
    always_comb begin
        rd_hit = 1'b1;
        rd_byte = 8'h00;
        case (rd_off)
            `FRD_OFF_DIN: begin
                case (mode_q)
                    FRD_MODE_ENHANCED: begin
                        rd_byte = {drive_in.disk_changed_in,
                                   4'hf, // RULE_01
                                   rate_q, // RULE_02
                                   frd_is_slow(rate_q)}; // RULE_03
                    end
                    FRD_MODE_COMPACT: begin
                        rd_byte = {!drive_in.disk_changed_in, // RULE_04
                                   3'b000, // RULE_05
                                   dout_q[`FRD_BIT_DMAGATE], // RULE_06
                                   skip_precomp_q, // RULE_07 RULE_12
                                   rate_q}; // RULE_02
                    end
                    default: begin
                        rd_byte = {drive_in.disk_changed_in, 7'h00};
                    end
                endcase
            end
            `FRD_OFF_DOUT: rd_byte = dout_q;
            `FRD_OFF_MODE: rd_byte = {6'h00, mode_q};
            `FRD_OFF_MAIN: rd_byte = main_status; // RULE_14
            `FRD_OFF_DATA: begin
                case (phase_q)
                    FRD_PH_RESULT0: rd_byte = status_zero_q; // RULE_13
                    FRD_PH_RESULT1: rd_byte = status_one_q; // RULE_13
                    default: rd_byte = 8'h00;
                endcase
            end
            default: rd_hit = 1'b0;
        endcase
    end

    // Read response register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            rresp_q <= `FRD_RESP_OKAY;
        end else if (clk_en) begin
            if (do_read) begin
                rvalid_q <= 1'b1;
                rdata_q <= {24'h00_0000, rd_byte};
                rresp_q <= rd_hit ? `FRD_RESP_OKAY : `FRD_RESP_SLVERR;
            end else if (s_axi_rready) begin
                rvalid_q <= 1'b0;
            end
        end
    end

    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;

endmodule // frd_rate_diag_regs

`default_nettype wire

// >>> verification/fdc_rate_diag_status_regs_bench.sv
// Self-checking bench of the register block.
// Assumes host model and checker compiled beside it.
`timescale 1ns/1ps
`default_nettype none
`include "frd_consts.svh"
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin n_fail++; \
    $display("Error at %0t: got %h expected %h", $time, g, e); end end

module fdc_rate_diag_status_regs_bench;
    import frd_pkg::*;
    logic aclk = 0, aresetn = 0, clk_en = 1, req = 0, we = 0, slow = 0, done;
    logic [7:0] addr = 0, s_axi_awaddr, s_axi_araddr;
    logic [31:0] wd = 0, rd, s_axi_wdata, s_axi_rdata;
    logic [1:0] resp, s_axi_bresp, s_axi_rresp, data_rate;
    logic [3:0] s_axi_wstrb;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic single_density, dense_rate_flag, dma_gate_enable, soft_reset, result_phase;
    logic exec_end = 0, polling_active = 0, drive_busy = 0, dc, hd;
    frd_drive_t drive_in = '0;
    frd_exec_end_t exec_info = '0;
    logic [33:0] exp_q[$];
    logic [1:0] c;
    int n_fail = 0, num_checks = 0;

    // ----------------------------------------
    // Clock, parts and result watcher
    // ----------------------------------------
    initial forever #4 aclk = ~aclk;

    frd_rate_diag_regs dut (.aclk, .aresetn, .clk_en, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .drive_in, .exec_end,
        .exec_info, .polling_active, .drive_busy, .data_rate, .single_density,
        .dense_rate_flag, .dma_gate_enable, .soft_reset, .result_phase);
    frd_host_model host (.aclk, .aresetn, .req, .we, .slow, .addr, .wd, .done, .rd, .resp,
        .awaddr(s_axi_awaddr), .awvalid(s_axi_awvalid), .awready(s_axi_awready),
        .wdata(s_axi_wdata), .wstrb(s_axi_wstrb), .wvalid(s_axi_wvalid), .wready(s_axi_wready),
        .bresp(s_axi_bresp), .bvalid(s_axi_bvalid), .bready(s_axi_bready),
        .araddr(s_axi_araddr), .arvalid(s_axi_arvalid), .arready(s_axi_arready),
        .rdata(s_axi_rdata), .rresp(s_axi_rresp), .rvalid(s_axi_rvalid), .rready(s_axi_rready));

    always @(posedge aclk) begin
        if (done === 1'b1) begin
            if (exp_q.size() == 0) n_fail++;
            else `CHK({resp, rd}, exp_q.pop_front())
        end
    end

    task automatic report_and_stop();
        $display("Checks %0d, mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // One transfer, expected answer noted first
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        input logic [33:0] e);
        int n;
        exp_q.push_back(e);
        we <= w;
        addr <= a;
        wd <= d;
        req <= 1'b1;
        @(posedge aclk);
        req <= 1'b0;
        n = 0;
        while (done !== 1'b1 && n < 60) begin
            @(posedge aclk);
            n++;
        end
        if (n == 60) begin
            n_fail++;
            report_and_stop();
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d, {`FRD_RESP_OKAY, 32'h0});
    endtask
    task automatic rdc(input logic [7:0] a, input logic [7:0] e);
        xfer(1'b0, a, 32'h0, {`FRD_RESP_OKAY, 24'h0, e});
    endtask

    // Execution end, then result bytes
    task automatic run_exec(input logic [1:0] tc, input logic poll, input logic [1:0] etc);
        logic [7:0] s1;
        logic [1:0] dn;
        logic hs;
        s1 = 8'($urandom);
        dn = 2'($urandom);
        hs = 1'($urandom);
        drive_in.head_select_out <= hs;
        polling_active <= poll;
        exec_info <= '{tc, 1'b1, 1'b1, 1'b0, dn, s1, 1'b1};
        exec_end <= 1'b1;
        @(posedge aclk);
        exec_end <= 1'b0;
        @(posedge aclk);
        `CHK(result_phase, 1'b1)
        rdc(`FRD_OFF_MAIN, 8'hc0);
        rdc(`FRD_OFF_DATA, {etc, 3'b110, hs, dn});
        rdc(`FRD_OFF_DATA, s1);
        rdc(`FRD_OFF_DATA, 8'h00);
        rdc(`FRD_OFF_MAIN, 8'h80);
    endtask

    // ----------------------------------------
    // Main sequence and watchdog
    // ----------------------------------------
    initial begin
        #400000;
        n_fail++;
        report_and_stop();
    end

    initial begin
        void'($urandom(32'h6dae));
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        `CHK(data_rate, `FRD_RST_RATE)
        run_exec(2'b11, 1'b1, 2'b11);
        run_exec(2'b00, 1'b0, 2'b00);
        for (int i = 0; i < 3; i++) run_exec(2'(i), 1'b0, 2'(i));
        run_exec(2'b11, 1'b1, 2'b01);
        dc = 1'($urandom);
        drive_in.disk_changed_in <= dc;
        rdc(`FRD_OFF_DIN, {dc, 7'h0});
        wr(`FRD_OFF_MODE, 32'h1);
        for (int i = 0; i < 4; i++) begin
            c = 2'(i);
            hd = !(c == `FRD_RATE_1M || c == `FRD_RATE_500K);
            wr(`FRD_OFF_CFG, {30'h0, c});
            `CHK(data_rate, c)
            `CHK(dense_rate_flag, !hd)
            rdc(`FRD_OFF_DIN, {dc, 4'hf, c, hd});
            wr(`FRD_OFF_RSEL, {26'h0, 1'b1, 3'h0, ~c});
            `CHK(data_rate, ~c)
            `CHK(single_density, ~c != `FRD_RATE_1M)
        end
        // Refused places, slow host
        slow <= 1'b1;
        xfer(1'b0, `FRD_OFF_CFG, 32'h0, {`FRD_RESP_SLVERR, 32'h0});
        xfer(1'b0, 8'h3c, 32'h0, {`FRD_RESP_SLVERR, 32'h0});
        xfer(1'b1, 8'h3c, 32'h5, {`FRD_RESP_SLVERR, 32'h0});
        slow <= 1'b0;
        // Compact view, soft reset keeps rate and skip bit
        c = 2'($urandom);
        wr(`FRD_OFF_MODE, 32'h2);
        wr(`FRD_OFF_DOUT, 32'h0c);
        wr(`FRD_OFF_CFG, {29'h0, 1'b1, c});
        `CHK(dma_gate_enable, 1'b1)
        rdc(`FRD_OFF_DIN, {~dc, 3'h0, 2'b11, c});
        wr(`FRD_OFF_DOUT, 32'h08);
        `CHK(soft_reset, 1'b1)
        wr(`FRD_OFF_DOUT, 32'h0c);
        `CHK(soft_reset, 1'b0)
        `CHK(data_rate, c)
        rdc(`FRD_OFF_DIN, {~dc, 3'h0, 2'b11, c});
        // Frozen enable swallows an execution end
        clk_en <= 1'b0;
        exec_info.has_result <= 1'b1;
        exec_end <= 1'b1;
        @(posedge aclk);
        exec_end <= 1'b0;
        clk_en <= 1'b1;
        @(posedge aclk);
        `CHK(result_phase, 1'b0)
        // Hardware reset mid-run
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        `CHK(data_rate, `FRD_RST_RATE)
        rdc(`FRD_OFF_DIN, {dc, 7'h0});
        repeat (2) @(posedge aclk);
        report_and_stop();
    end
endmodule // fdc_rate_diag_status_regs_bench
`default_nettype wire

// >>> verification/frd_host_model.sv
// Host model: one AXI4-Lite transfer per request.
// Assumes req pulses only while idle.
`timescale 1ns/1ps
`default_nettype none

module frd_host_model (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Bench requests
    input wire logic req,
    input wire logic we,
    input wire logic slow,
    input wire logic [7:0] addr,
    input wire logic [31:0] wd,
    output logic done,
    output logic [31:0] rd,
    output logic [1:0] resp,
    // Master channels
    output logic [7:0] awaddr,
    output logic awvalid,
    input wire logic awready,
    output logic [31:0] wdata,
    output logic [3:0] wstrb,
    output logic wvalid,
    input wire logic wready,
    input wire logic [1:0] bresp,
    input wire logic bvalid,
    output logic bready,
    output logic [7:0] araddr,
    output logic arvalid,
    input wire logic arready,
    input wire logic [31:0] rdata,
    input wire logic [1:0] rresp,
    input wire logic rvalid,
    output logic rready
);
    logic busy_q;

    // ----------------------------------------
    // Transfer engine
    // ----------------------------------------
    always_ff @(posedge aclk) begin
        done <= 1'b0;
        if (!aresetn) begin
            busy_q <= 1'b0;
            {awvalid, wvalid, arvalid, bready, rready} <= 5'h0;
        end else if (req && !busy_q) begin
            busy_q <= 1'b1;
            awaddr <= addr;
            araddr <= addr;
            wdata <= wd;
            wstrb <= 4'hf;
            awvalid <= we;
            wvalid <= we;
            arvalid <= !we;
            bready <= we && !slow;
            rready <= !we && !slow;
        end else if (busy_q) begin
            // Released lines show the inverse
            if (awvalid && awready) begin
                awvalid <= 1'b0;
                awaddr <= ~awaddr;
            end
            if (wvalid && wready) begin
                wvalid <= 1'b0;
                wdata <= ~wdata;
            end
            if (arvalid && arready) begin
                arvalid <= 1'b0;
                araddr <= ~araddr;
            end
            if (bvalid) bready <= 1'b1;
            if (rvalid) rready <= 1'b1;
            if ((bvalid && bready) || (rvalid && rready)) begin
                busy_q <= 1'b0;
                done <= 1'b1;
                bready <= 1'b0;
                rready <= 1'b0;
                rd <= bvalid ? 32'h0 : rdata;
                resp <= bvalid ? bresp : rresp;
            end
        end
    end
endmodule // frd_host_model
`default_nettype wire

// >>> verification/frd_regs_props.sv
// Checker of bus answers, rate outputs and result phase.
// Assumes binding onto frd_rate_diag_regs.
`timescale 1ns/1ps
`default_nettype none
`include "frd_consts.svh"

module frd_regs_props
    import frd_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    // Clock and control
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic clk_en,
    // Write channels
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // Read channels
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Sequencer and state
    input wire logic exec_end,
    input wire frd_pkg::frd_exec_end_t exec_info,
    input wire logic [1:0] data_rate,
    input wire logic single_density,
    input wire logic dense_rate_flag,
    input wire logic result_phase
);
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // Address and data taken together
    sequence wr_take_s;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && clk_en;
    endsequence
    sequence cfg_take_s;
        wr_take_s ##0 (s_axi_awaddr == `FRD_OFF_CFG && s_axi_wstrb[0]);
    endsequence

    rate_reset_a: assert property ($rose(aresetn) |-> data_rate == `FRD_RST_RATE)
        else $error("rate not 250k after reset");
    cfg_rate_a: assert property (cfg_take_s |-> ##3 data_rate == $past(s_axi_wdata[1:0], 3))
        else $error("config rate not applied");
    dense_flag_a: assert property ($stable(data_rate) |->
        dense_rate_flag == (data_rate == `FRD_RATE_1M || data_rate == `FRD_RATE_500K))
        else $error("dense flag wrong for rate");
    single_fm_a: assert property (single_density |-> data_rate != `FRD_RATE_1M)
        else $error("single density at 1M");
    result_go_a: assert property (exec_end && clk_en && exec_info.has_result |=> result_phase)
        else $error("no result phase");
    freeze_hold_a: assert property (!clk_en |=> $stable(data_rate) && $stable(result_phase))
        else $error("state moved while frozen");
    wr_answer_a: assert property (wr_take_s |-> ##[1:2] s_axi_bvalid)
        else $error("write response late");
    rd_answer_a: assert property (s_axi_arvalid && s_axi_arready && clk_en |=> s_axi_rvalid)
        else $error("read data late");
    b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
endmodule // frd_regs_props

bind frd_rate_diag_regs frd_regs_props #(.ADDR_W(ADDR_W)) u_props (.aclk, .aresetn, .clk_en,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .exec_end, .exec_info, .data_rate,
    .single_density, .dense_rate_flag, .result_phase);
`default_nettype wire
